// >>> sbp2as_map.svh
// Offsets, field positions and reset values of the agent status bank
`ifndef SBP2AS_MAP_SVH
`define SBP2AS_MAP_SVH
`define SBP2AS_CTRL_OFS      8'h50
`define SBP2AS_STATUS_OFS    8'h5C
`define SBP2AS_STRIDE        8
`define SBP2AS_STATE_LSB     0
`define SBP2AS_DOORBELL_BIT  2
`define SBP2AS_UNSOL_BIT     3
`define SBP2AS_CTL_LSB       4
`define SBP2AS_DEAD_IDX      0
`define SBP2AS_RST_IDX       1
`define SBP2AS_DCLR_IDX      2
`define SBP2AS_UCLR_IDX      3
`define SBP2AS_CTL_MASK      32'hF0F0F0F0
`define SBP2AS_SEL_LSB       0
`define SBP2AS_AUTO_BIT      11
`define SBP2AS_SEL_RESET     2'h0
`define SBP2AS_AUTO_RESET    1'h0
`define SBP2AS_STATUS_RESET  32'h00000000
`define SBP2AS_TL_PREFIX     3'h7
`endif

// >>> sbp2as_pkg.sv
// Types shared by the agent status bank
package sbp2as_pkg;
	typedef enum logic [1:0] {
		AGT_RESET     = 2'h0,
		AGT_ACTIVE    = 2'h1,
		AGT_SUSPENDED = 2'h2,
		AGT_DEAD      = 2'h3
	} sbp2as_state_t;

	typedef struct packed {
		logic [3:0] doorbellWrite;
		logic [3:0] unsolEnableWrite;
		logic       txTlabelValid;
		logic [5:0] txTlabel;
	} sbp2as_link_t;

	typedef struct packed {
		logic [3:0] setActive;
		logic [3:0] setSuspended;
	} sbp2as_prog_t;
endpackage : sbp2as_pkg

// >>> sbp2as_status_bank.sv
// Status and control bank for four command block agents
//
// How it works
// R01 - Four identical agents, one byte each
// R02 - Zero after reset and bus reset
// R03 - State codes: Reset, Active, Suspended, Dead
// R04 - Doorbell write sets doorbell pending
// R05 - Host doorbell clear bit drops pending
// R06 - Unsolicited enable write arms flag
// R07 - Matching transmitted tLabel clears armed flag
// R08 - Host unsolicited clear bit drops armed
// R09 - Force dead bit sets state Dead
// R10 - Force reset bit sets state Reset
// R11 - Control bits pulse, read zero; zeros ignored
// R12 - Auto clear enable bit gates tLabel clearing
// R13 - Agent select forms tLabel middle bits
//
// The Avalon-MM register port was decided locally.
`timescale 1ns/1ns
`include "sbp2as_map.svh"

module sbp2as_status_bank (
	// Clock, reset, enable
	input  wire logic                   clk,
	input  wire logic                   rst,
	input  wire logic                   ce,
	// Link side events
	input  wire logic                   busReset,
	input  wire sbp2as_pkg::sbp2as_link_t linkEvt,
	input  wire sbp2as_pkg::sbp2as_prog_t progEvt,
	// Avalon-MM slave
	input  wire logic [7:0]             avs_address,
	input  wire logic                   avs_read,
	input  wire logic                   avs_write,
	input  wire logic [31:0]            avs_writedata,
	input  wire logic [3:0]             avs_byteenable,
	output logic      [31:0]            avs_readdata,
	output logic                        avs_waitrequest,
	// Status view
	output logic      [31:0]            statusWord
);

	// Agent state
	sbp2as_pkg::sbp2as_state_t agentState [4];
	logic [3:0] doorbellPending;
	logic [3:0] unsolStatusArmed;
	logic [1:0] agentSelect;
	logic       tlabelAutoClearEn;
	logic       ack;

	// Bus decode
	logic        request;
	logic        wrAccept;
	logic        hitStatus;
	logic        hitCtrl;
	logic [31:0] ctrlWord;
	logic [31:0] next_readdata;

	// Host control pulses
	logic [3:0] forceDead;
	logic [3:0] forceResetState;
	logic [3:0] doorbellClear;
	logic [3:0] unsolStatusClear;
	logic       autoHit;

	// Control nibble of one agent from a write
	function automatic logic [3:0] hostCtl(
		input logic [31:0] data,
		input logic [3:0]  be,
		input int          k
	);
		logic [3:0] v;
		v = data[k*`SBP2AS_STRIDE + `SBP2AS_CTL_LSB +: 4];
		return be[k] ? v : 4'h0;
	endfunction : hostCtl

	// Status byte of one agent
	function automatic logic [7:0] agentByte(
		input logic [1:0] st,
		input logic       db,
		input logic       us
	);
		logic [7:0] b;
		b = 8'h00;
		b[`SBP2AS_STATE_LSB +: 2] = st;
		b[`SBP2AS_DOORBELL_BIT] = db;
		b[`SBP2AS_UNSOL_BIT] = us;
		return b;
	endfunction : agentByte

	// Handshake: one wait state per request
	assign request = avs_read | avs_write;
	assign avs_waitrequest = request & ~(ack & ce);
	assign wrAccept = ce & ack & avs_write;
	assign hitStatus = (avs_address == `SBP2AS_STATUS_OFS);
	assign hitCtrl = (avs_address == `SBP2AS_CTRL_OFS);

	always_ff @(posedge clk) begin
		if (rst) begin
			ack <= 1'b0;
		end else if (ce) begin
			ack <= request & ~ack;
		end
	end

	// Write-one pulses, lane gated
	always_comb begin
		logic [3:0] c;
		c = 4'h0;
		forceDead = 4'h0;
		forceResetState = 4'h0;
		doorbellClear = 4'h0;
		unsolStatusClear = 4'h0;
		for (int k = 0; k < 4; k++) begin
			c = (wrAccept && hitStatus) ? hostCtl(avs_writedata, avs_byteenable, k) : 4'h0; // see R11
			forceDead[k] = c[`SBP2AS_DEAD_IDX];
			forceResetState[k] = c[`SBP2AS_RST_IDX];
			doorbellClear[k] = c[`SBP2AS_DCLR_IDX];
			unsolStatusClear[k] = c[`SBP2AS_UCLR_IDX];
		end
	end

	// Agent control register
	always_ff @(posedge clk) begin
		if (rst) begin
			agentSelect <= `SBP2AS_SEL_RESET;
			tlabelAutoClearEn <= `SBP2AS_AUTO_RESET;
		end else if (wrAccept && hitCtrl) begin
			if (avs_byteenable[0]) begin
				agentSelect <= avs_writedata[`SBP2AS_SEL_LSB +: 2]; // see R13
			end
			if (avs_byteenable[1]) begin
				tlabelAutoClearEn <= avs_writedata[`SBP2AS_AUTO_BIT]; // see R12
			end
		end
	end

	// Transmitted tLabel 111b, agent, any low bit
	assign autoHit = tlabelAutoClearEn // see R12
		&& linkEvt.txTlabelValid
		&& (linkEvt.txTlabel[5:3] == `SBP2AS_TL_PREFIX) // see R07
		&& (linkEvt.txTlabel[2:1] == agentSelect); // see R13

	// Agent state fields
	always_ff @(posedge clk) begin
		if (rst) begin
			for (int k = 0; k < 4; k++) begin
				agentState[k] <= sbp2as_pkg::AGT_RESET; // see R02
			end
		end else if (ce) begin
			for (int k = 0; k < 4; k++) begin // see R01
				if (busReset) begin
					agentState[k] <= sbp2as_pkg::AGT_RESET; // see R02
				end else if (forceDead[k]) begin
					agentState[k] <= sbp2as_pkg::AGT_DEAD; // see R09
				end else if (forceResetState[k]) begin
					agentState[k] <= sbp2as_pkg::AGT_RESET; // see R10
				end else if (progEvt.setActive[k]) begin
					agentState[k] <= sbp2as_pkg::AGT_ACTIVE; // see R03
				end else if (progEvt.setSuspended[k]) begin
					agentState[k] <= sbp2as_pkg::AGT_SUSPENDED; // see R03
				end
			end
		end
	end

	// Doorbell pending flags, set wins over clear
	always_ff @(posedge clk) begin
		if (rst) begin
			doorbellPending <= 4'h0;
		end else if (ce) begin
			for (int k = 0; k < 4; k++) begin
				if (busReset) begin
					doorbellPending[k] <= 1'b0; // see R02
				end else if (linkEvt.doorbellWrite[k]) begin
					doorbellPending[k] <= 1'b1; // see R04
				end else if (doorbellClear[k]) begin
					doorbellPending[k] <= 1'b0; // see R05
				end
			end
		end
	end

	// Unsolicited status armed flags, set wins over clear
	always_ff @(posedge clk) begin
		if (rst) begin
			unsolStatusArmed <= 4'h0;
		end else if (ce) begin
			for (int k = 0; k < 4; k++) begin
				if (busReset) begin
					unsolStatusArmed[k] <= 1'b0; // see R02
				end else if (linkEvt.unsolEnableWrite[k]) begin
					unsolStatusArmed[k] <= 1'b1; // see R06
				end else if (unsolStatusClear[k]) begin
					unsolStatusArmed[k] <= 1'b0; // see R08
				end else if (autoHit && (agentSelect == 2'(k))) begin
					unsolStatusArmed[k] <= 1'b0; // see R07
				end
			end
		end
	end

	// Register views
	always_comb begin
		statusWord = `SBP2AS_STATUS_RESET;
		for (int k = 0; k < 4; k++) begin
			statusWord[k*`SBP2AS_STRIDE +: 8] =
				agentByte(agentState[k], doorbellPending[k], unsolStatusArmed[k]); // see R11
		end
	end

	always_comb begin
		ctrlWord = 32'h00000000;
		ctrlWord[`SBP2AS_SEL_LSB +: 2] = agentSelect;
		ctrlWord[`SBP2AS_AUTO_BIT] = tlabelAutoClearEn;
	end

	// Read data captured in the wait cycle
	always_comb begin
		next_readdata = 32'h00000000;
		if (hitStatus) begin
			next_readdata = statusWord;
		end else if (hitCtrl) begin
			next_readdata = ctrlWord;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			avs_readdata <= 32'h00000000;
		end else if (ce && avs_read && !ack) begin
			avs_readdata <= next_readdata;
		end
	end

	// Checks
	sequence s_status_wr;
		wrAccept && hitStatus && !busReset;
	endsequence

	sequence s_status_rd;
		ce && avs_read && !ack && hitStatus ##1 ce && avs_read && ack;
	endsequence

	property p_one_agent_alike;
		@(posedge clk) disable iff (rst)
		ce && linkEvt.unsolEnableWrite[3] && !busReset |=> statusWord[27];
	endproperty
	a_one_agent_alike: assert property (p_one_agent_alike) // see R01
		else $error("agent 3 armed flag not set");

	property p_bus_reset_zero;
		@(posedge clk) disable iff (rst)
		ce && busReset |=> statusWord == 32'h00000000;
	endproperty
	a_bus_reset_zero: assert property (p_bus_reset_zero) // see R02
		else $error("status not zero after bus reset");

	property p_active_code;
		@(posedge clk) disable iff (rst)
		ce && progEvt.setActive[1] && !forceDead[1] && !forceResetState[1] && !busReset
		|=> statusWord[9:8] == 2'h1;
	endproperty
	a_active_code: assert property (p_active_code) // see R03
		else $error("active state code wrong");

	property p_doorbell_set;
		@(posedge clk) disable iff (rst)
		ce && linkEvt.doorbellWrite[0] && !busReset |=> doorbellPending[0] [*1] ##0 statusWord[2];
	endproperty
	a_doorbell_set: assert property (p_doorbell_set) // see R04
		else $error("doorbell pending not set");

	property p_doorbell_clear;
		@(posedge clk) disable iff (rst)
		s_status_wr ##0 avs_byteenable[1] && avs_writedata[14] && !linkEvt.doorbellWrite[1]
		|=> !statusWord[10];
	endproperty
	a_doorbell_clear: assert property (p_doorbell_clear) // see R05
		else $error("doorbell pending not cleared");

	property p_unsol_set;
		@(posedge clk) disable iff (rst)
		ce && linkEvt.unsolEnableWrite[2] && !busReset |=> statusWord[19];
	endproperty
	a_unsol_set: assert property (p_unsol_set) // see R06
		else $error("armed flag not set");

	property p_auto_clear;
		@(posedge clk) disable iff (rst)
		ce && autoHit && !linkEvt.unsolEnableWrite[agentSelect] && !busReset
		|=> !unsolStatusArmed[$past(agentSelect)];
	endproperty
	a_auto_clear: assert property (p_auto_clear) // see R07
		else $error("tLabel match did not clear armed flag");

	property p_unsol_clear;
		@(posedge clk) disable iff (rst)
		s_status_wr ##0 avs_byteenable[0] && avs_writedata[7] && !linkEvt.unsolEnableWrite[0]
		|=> !statusWord[3];
	endproperty
	a_unsol_clear: assert property (p_unsol_clear) // see R08
		else $error("armed flag not cleared by host");

	property p_force_dead;
		@(posedge clk) disable iff (rst)
		s_status_wr ##0 avs_byteenable[0] && avs_writedata[4] |=> statusWord[1:0] == 2'h3;
	endproperty
	a_force_dead: assert property (p_force_dead) // see R09
		else $error("force dead did not give Dead");

	property p_force_reset;
		@(posedge clk) disable iff (rst)
		s_status_wr ##0 avs_byteenable[0] && avs_writedata[5] && !avs_writedata[4]
		|=> statusWord[1:0] == 2'h0;
	endproperty
	a_force_reset: assert property (p_force_reset) // see R10
		else $error("force reset did not give Reset");

	property p_ctl_reads_zero;
		@(posedge clk) disable iff (rst)
		s_status_rd |-> (avs_readdata & `SBP2AS_CTL_MASK) == 32'h00000000 && !avs_waitrequest;
	endproperty
	a_ctl_reads_zero: assert property (p_ctl_reads_zero) // see R11
		else $error("control bits read nonzero");

	property p_auto_gated;
		@(posedge clk) disable iff (rst)
		ce && !tlabelAutoClearEn && unsolStatusArmed[2] && !unsolStatusClear[2] && !busReset
		|=> unsolStatusArmed[2];
	endproperty
	a_auto_gated: assert property (p_auto_gated) // see R12
		else $error("armed flag cleared while auto clear off");

	property p_select_match;
		@(posedge clk) disable iff (rst)
		ce && autoHit && agentSelect != 2'h3 && unsolStatusArmed[3]
		&& !unsolStatusClear[3] && !busReset |=> unsolStatusArmed[3];
	endproperty
	a_select_match: assert property (p_select_match) // see R13
		else $error("unselected agent flag cleared");

endmodule : sbp2as_status_bank

// >>> sbp2as_initiator.sv
// Remote initiator model writing agent registers over the link
`timescale 1ns/1ns
module sbp2as_initiator (
	// Clock
	input  wire logic                clk,
	// Link events
	output sbp2as_pkg::sbp2as_link_t linkEvt
);
	initial linkEvt = '0;

	// One-cycle event: doorbell, enable writes, transmitted tLabel
	task automatic pulse(input logic [3:0] db, input logic [3:0] us,
			input logic tv, input logic [5:0] tl);
		@(posedge clk);
		linkEvt <= {db, us, tv, tl};
		@(posedge clk);
		linkEvt <= '0;
	endtask : pulse
endmodule : sbp2as_initiator

// >>> tb.sv
// Self-checking bench of the agent status bank
`timescale 1ns/1ns
module tb;
	logic                     clk = 1'b0;
	logic                     rst = 1'b1;
	logic                     busRst = 1'b0;
	logic                     ceOn = 1'b1;
	sbp2as_pkg::sbp2as_link_t linkEvt;
	sbp2as_pkg::sbp2as_prog_t prog = '0;
	logic [7:0]               addr = 8'h00;
	logic                     rd = 1'b0;
	logic                     wr = 1'b0;
	logic [31:0]              wdata = 32'h00000000;
	logic [3:0]               bEn = 4'hF;
	logic [31:0]              rdata;
	logic                     waitReq;
	logic [31:0]              status;
	logic [31:0]              exp = 32'h00000000;
	int                       nMismatch = 0;
	int                       nTests = 0;

	always #4 clk = ~clk;

	sbp2as_status_bank uut (
		.clk(clk), .rst(rst), .ce(ceOn), .busReset(busRst), .linkEvt(linkEvt),
		.progEvt(prog), .avs_address(addr), .avs_read(rd), .avs_write(wr),
		.avs_writedata(wdata), .avs_byteenable(bEn), .avs_readdata(rdata),
		.avs_waitrequest(waitReq), .statusWord(status)
	);

	sbp2as_initiator ini (
		.clk(clk), .linkEvt(linkEvt)
	);

	task automatic conclude;
		if (nMismatch == 0 && nTests > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : conclude

	task automatic cmp(input logic [31:0] got, input logic [31:0] want);
		nTests++;
		if (got !== want) begin
			nMismatch++;
			$display("BAD %0t got %h want %h", $time, got, want);
		end
	endtask : cmp

	// Bus cycle held until waitrequest is seen low at a rising edge
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
			input logic [3:0] be, output logic [31:0] q);
		@(posedge clk);
		addr  <= a;
		wr    <= w;
		rd    <= ~w;
		wdata <= d;
		bEn   <= be;
		do begin
			@(posedge clk);
		end while (waitReq !== 1'b0);
		q = rdata;
		wr <= 1'b0;
		rd <= 1'b0;
	endtask : xfer

	task automatic wreg(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
		logic [31:0] q;
		xfer(1'b1, a, d, be, q);
	endtask : wreg

	task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		xfer(1'b0, a, 32'h00000000, 4'hF, q);
		cmp(q, e);
	endtask : rdchk

	task automatic look(input logic [31:0] e);
		@(negedge clk);
		cmp(status, e);
		rdchk(8'h5C, e);
	endtask : look

	task automatic ev(input logic [3:0] a, input logic [3:0] s);
		@(posedge clk);
		prog <= '{setActive: a, setSuspended: s};
		@(posedge clk);
		prog <= '0;
	endtask : ev

	initial begin
		#40000;
		nMismatch++;
		conclude();
	end

	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		look(32'h00000000);
		for (int k = 0; k < 4; k++) begin
			ini.pulse(4'(1 << k), 4'h0, 1'b0, 6'h00);
			exp[k*8+2] = 1'b1;
			look(exp);
		end
		ini.pulse(4'h0, 4'hF, 1'b0, 6'h00);
		exp = exp | 32'h08080808;
		look(exp);
		wreg(8'h5C, 32'h0F0F0F0F, 4'hF);
		wreg(8'h5C, 32'h0000FFFF, 4'hC);
		look(exp);
		wreg(8'h5C, 32'h00804000, 4'hF);
		exp = exp & ~32'h00080400;
		look(exp);
		wreg(8'h50, 32'h00000003, 4'hF);
		ini.pulse(4'h0, 4'h0, 1'b1, 6'h3F);
		look(exp);
		wreg(8'h50, 32'h00000803, 4'hF);
		ini.pulse(4'h0, 4'h0, 1'b1, 6'h37);
		look(exp);
		ini.pulse(4'h0, 4'h0, 1'b1, 6'h3E);
		exp[27] = 1'b0;
		look(exp);
		ev(4'h1, 4'h2);
		exp[1:0] = 2'h1;
		exp[9:8] = 2'h2;
		look(exp);
		wreg(8'h5C, 32'h00100010, 4'hF);
		exp[1:0] = 2'h3;
		exp[17:16] = 2'h3;
		look(exp);
		wreg(8'h5C, 32'h00000020, 4'hF);
		exp[1:0] = 2'h0;
		look(exp);
		wreg(8'h44, 32'hFFFFFFFF, 4'hF);
		rdchk(8'h44, 32'h00000000);
		look(exp);
		wreg(8'h5C, 32'hFFFFFFFF, 4'hF);
		look(32'h03030303);
		@(posedge clk);
		busRst <= 1'b1;
		@(posedge clk);
		busRst <= 1'b0;
		look(32'h00000000);
		rdchk(8'h50, 32'h00000803);
		// Frozen bank ignores a doorbell write
		@(posedge clk);
		ceOn <= 1'b0;
		ini.pulse(4'h1, 4'h0, 1'b0, 6'h00);
		@(negedge clk);
		cmp(status, 32'h00000000);
		@(posedge clk);
		ceOn <= 1'b1;
		look(32'h00000000);
		conclude();
	end
endmodule : tb
